// >>> design/sld_params.svh
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH

// Backplane geometry
`define SLD_NUM_BACKPLANE 4
`define SLD_STEPS_PER_FRAME 8
`define SLD_STEP_W 3

// Default panel width: cells of two segment lines
`define SLD_NUM_CELLS 4
`define SLD_SPLIT_DEFAULT 6

// Refresh range of typical glass, in Hz
`define SLD_REFRESH_MIN_HZ 30
`define SLD_REFRESH_MAX_HZ 200

// Byte layout of one cell
`define SLD_CELL_LOW_MSB 7
`define SLD_CELL_LOW_LSB 4
`define SLD_CELL_HIGH_MSB 3
`define SLD_CELL_HIGH_LSB 0

// Output reset values
`define SLD_SEG_RESET 1'b0

`endif

// >>> design/sld_pkg.sv
package sld_pkg;
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] drive_en;
	} sld_backplane_t;

	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] data;
	} sld_cell_wr_t;
endpackage

// >>> design/sld_cell_mem.sv
`include "sld_params.svh"

// Character memory: one byte per cell, registered read
module sld_cell_mem #(
	parameter int NUM_CELLS = `SLD_NUM_CELLS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire sld_pkg::sld_cell_wr_t wr,
	output logic [NUM_CELLS*8-1:0] rd_data
);
	logic [7:0] mem_r [NUM_CELLS];
	logic [7:0] mem_nxt [NUM_CELLS];
	logic [NUM_CELLS*8-1:0] rd_nxt;

	always_comb begin
		for (int i = 0; i < NUM_CELLS; i++) begin
			mem_nxt[i] = mem_r[i];
			if (wr.wr_en && (wr.addr == 8'(i))) begin
				mem_nxt[i] = wr.data;
			end
			rd_nxt[i*8 +: 8] = mem_nxt[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_CELLS; i++) begin
				mem_r[i] <= 8'h00;
			end
			rd_data <= '0;
		end else begin
			mem_r <= mem_nxt;
			rd_data <= rd_nxt;
		end
	end
endmodule

// >>> design/sld_driver.sv
`include "sld_params.svh"

module sld_driver #(
	parameter int NUM_CELLS = `SLD_NUM_CELLS,
	parameter int SPLIT = `SLD_SPLIT_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic refresh_step_tick,
	input wire sld_pkg::sld_cell_wr_t cell_wr,
	output sld_pkg::sld_backplane_t backplane_line,
	output logic [SPLIT-1:0] segment_line_low_port,
	output logic [2*NUM_CELLS-SPLIT-1:0] segment_line_high_port,
	output logic frame_start
);
	localparam int NSEG = 2 * NUM_CELLS;

	////////////////////////////////////////////////////////////
	// Step sequencer
	typedef enum logic [7:0] {
		SLD_S0 = 8'h01,
		SLD_S1 = 8'h02,
		SLD_S2 = 8'h04,
		SLD_S3 = 8'h08,
		SLD_S4 = 8'h10,
		SLD_S5 = 8'h20,
		SLD_S6 = 8'h40,
		SLD_S7 = 8'h80
	} sld_step_t;

	sld_step_t step_r, step_nxt;
	logic [1:0] bp_idx;
	logic odd_step;

	always_comb begin
		step_nxt = step_r;
		bp_idx = 2'h0;
		odd_step = 1'b0;
		unique case (step_r)
			SLD_S0: begin
				bp_idx = 2'h0;
				odd_step = 1'b0;
				step_nxt = SLD_S1;
			end
			SLD_S1: begin
				bp_idx = 2'h0;
				odd_step = 1'b1;
				step_nxt = SLD_S2;
			end
			SLD_S2: begin
				bp_idx = 2'h1;
				odd_step = 1'b0;
				step_nxt = SLD_S3;
			end
			SLD_S3: begin
				bp_idx = 2'h1;
				odd_step = 1'b1;
				step_nxt = SLD_S4;
			end
			SLD_S4: begin
				bp_idx = 2'h2;
				odd_step = 1'b0;
				step_nxt = SLD_S5;
			end
			SLD_S5: begin
				bp_idx = 2'h2;
				odd_step = 1'b1;
				step_nxt = SLD_S6;
			end
			SLD_S6: begin
				bp_idx = 2'h3;
				odd_step = 1'b0;
				step_nxt = SLD_S7;
			end
			SLD_S7: begin
				bp_idx = 2'h3;
				odd_step = 1'b1;
				step_nxt = SLD_S0;
			end
			default: begin
				step_nxt = SLD_S0;
			end
		endcase
		if (!refresh_step_tick) begin
			step_nxt = step_r;
		end
	end

	////////////////////////////////////////////////////////////
	// Character memory
	logic [NUM_CELLS*8-1:0] cells;

	sld_cell_mem #(
		.NUM_CELLS(NUM_CELLS)
	) u_mem (
		.clk(clk),
		.rst_b(rst_b),
		.wr(cell_wr),
		.rd_data(cells)
	);

	////////////////////////////////////////////////////////////
	// Segment pattern for the active backplane
	logic [NSEG-1:0] lit_vec;

	for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
		logic [3:0] nib_lo;
		logic [3:0] nib_hi;
		assign nib_lo = cells[c*8+`SLD_CELL_LOW_LSB +: 4];
		assign nib_hi = cells[c*8+`SLD_CELL_HIGH_LSB +: 4];
		assign lit_vec[2*c] = nib_lo[bp_idx];
		assign lit_vec[2*c+1] = nib_hi[bp_idx];
	end

	////////////////////////////////////////////////////////////
	// Output registers
	sld_pkg::sld_backplane_t bp_r, bp_nxt;
	logic [NSEG-1:0] seg_r, seg_nxt;
	logic frame_r, frame_nxt;

	always_comb begin
		bp_nxt = bp_r;
		seg_nxt = seg_r;
		frame_nxt = 1'b0;
		if (refresh_step_tick) begin
			if (!odd_step) begin
				bp_nxt.drive_en = 4'h0;
				bp_nxt.drive_en[bp_idx] = 1'b1;
				bp_nxt.level = 4'h0;
				seg_nxt = lit_vec;
				frame_nxt = (step_r == SLD_S0);
			end else begin
				bp_nxt.level[bp_idx] = 1'b1;
				seg_nxt = ~seg_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			step_r <= SLD_S0;
			bp_r <= '0;
			seg_r <= {NSEG{`SLD_SEG_RESET}};
			frame_r <= 1'b0;
		end else begin
			step_r <= step_nxt;
			bp_r <= bp_nxt;
			seg_r <= seg_nxt;
			frame_r <= frame_nxt;
		end
	end

	assign backplane_line = bp_r;
	assign segment_line_low_port = seg_r[SPLIT-1:0];
	assign segment_line_high_port = seg_r[NSEG-1:SPLIT];
	assign frame_start = frame_r;

	////////////////////////////////////////////////////////////
	// Checks
	logic tick_q;
	logic [1:0] idx_q;
	logic [NSEG-1:0] lit_q;
	always_ff @(posedge clk) begin
		tick_q <= refresh_step_tick;
		idx_q <= bp_idx;
		lit_q <= lit_vec;
	end

	chk_single_drive: assert property (@(posedge clk) disable iff (!rst_b)
		$countones(bp_r.drive_en) <= 1)
		else $error("more than one backplane driven");
	chk_even_low: assert property (@(posedge clk) disable iff (!rst_b)
		refresh_step_tick && !odd_step |=> bp_r.drive_en[idx_q] && !bp_r.level[idx_q])
		else $error("even step backplane not low");
	chk_odd_high: assert property (@(posedge clk) disable iff (!rst_b)
		refresh_step_tick && odd_step |=> bp_r.drive_en[idx_q] && bp_r.level[idx_q])
		else $error("odd step backplane not high");
	chk_seg_load: assert property (@(posedge clk) disable iff (!rst_b)
		refresh_step_tick && !odd_step |=> seg_r == lit_q)
		else $error("segments not loaded from memory");
	chk_seg_invert: assert property (@(posedge clk) disable iff (!rst_b)
		refresh_step_tick && odd_step |=> seg_r == ~$past(seg_r))
		else $error("segments not inverted");
	chk_hold_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!refresh_step_tick |=> $stable(seg_r) && $stable(bp_r) && $stable(step_r))
		else $error("outputs moved without tick");
	chk_step_order: assert property (@(posedge clk) disable iff (!rst_b)
		refresh_step_tick && step_r == SLD_S7 |=> step_r == SLD_S0)
		else $error("sequence did not wrap");
	chk_frame_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		frame_r |-> $past(step_r) == SLD_S0 && tick_q)
		else $error("frame start misplaced");
	chk_reset_state: assert property (@(posedge clk)
		!rst_b |=> bp_r.drive_en == 4'h0 && seg_r == '0 && step_r == SLD_S0)
		else $error("reset state wrong");
	// Only the current backplane driven after an even step
	chk_float_rest: assert property (@(posedge clk) disable iff (!rst_b)
		refresh_step_tick && !odd_step |=> bp_r.drive_en == (4'h1 << idx_q))
		else $error("previous backplane not floated");

	cov_wrap: cover property (@(posedge clk) disable iff (!rst_b) refresh_step_tick && step_r == SLD_S7);
	cov_write: cover property (@(posedge clk) disable iff (!rst_b) cell_wr.wr_en && refresh_step_tick);
	cov_lit: cover property (@(posedge clk) disable iff (!rst_b) refresh_step_tick && !odd_step && |lit_vec);
	cov_bad_addr: cover property (@(posedge clk) disable iff (!rst_b) cell_wr.wr_en && cell_wr.addr >= 8'(NUM_CELLS));
endmodule

// >>> dv/sld_glass_model.sv
// Glass panel seen from the backplane pins, with the half-supply divider
module sld_glass_model (
	input wire sld_pkg::sld_backplane_t backplane_line,
	output logic [7:0] bp_state
);
	timeunit 1ns;
	timeprecision 1ns;

	// Per line: 00 low, 11 high, 01 mid level from the bias divider
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			bp_state[2*k +: 2] = backplane_line.drive_en[k] ? {2{backplane_line.level[k]}} : 2'b01;
		end
	end
endmodule

// >>> dv/sld_driver_test.sv
module sld_driver_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic refresh_step_tick = 1'b0;
	sld_pkg::sld_cell_wr_t cell_wr = '0;
	sld_pkg::sld_backplane_t backplane_line;
	logic [5:0] seg_lo;
	logic [1:0] seg_hi;
	logic frame_start;
	logic [7:0] bp_state;
	logic [7:0] mem [4];
	logic [7:0] corners [4] = '{8'hF0, 8'h0F, 8'h81, 8'h18};
	int mismatches = 0;
	int tests_run = 0;
	int step = 0;

	always #50 clk = ~clk;

	sld_driver #(.NUM_CELLS(4), .SPLIT(6)) sld_driver_i (.clk(clk), .rst_b(rst_b),
		.refresh_step_tick(refresh_step_tick), .cell_wr(cell_wr), .backplane_line(backplane_line),
		.segment_line_low_port(seg_lo), .segment_line_high_port(seg_hi), .frame_start(frame_start));
	sld_glass_model sld_glass_model_i (.backplane_line(backplane_line), .bp_state(bp_state));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bp(input sld_pkg::sld_backplane_t got, input sld_pkg::sld_backplane_t exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] exp_seg(input int s);
		logic [7:0] r;
		logic [3:0] nib;
		for (int j = 0; j < 8; j++) begin
			nib = j[0] ? mem[j / 2][3:0] : mem[j / 2][7:4];
			r[j] = nib[s / 2] ^ s[0];
		end
		return r;
	endfunction

	function automatic sld_pkg::sld_backplane_t exp_bp(input int s);
		sld_pkg::sld_backplane_t b;
		b.drive_en = 4'h1 << (s / 2);
		b.level = s[0] ? b.drive_en : 4'h0;
		return b;
	endfunction

	function automatic logic [7:0] exp_state(input int s);
		logic [7:0] r;
		for (int k = 0; k < 4; k++) begin
			r[2*k +: 2] = (k == s / 2) ? {2{s[0]}} : 2'b01;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic check_step(input logic fs);
		cmp_bp(backplane_line, exp_bp(step));
		cmp_byte({seg_hi, seg_lo}, exp_seg(step));
		cmp_byte({7'h00, frame_start}, {7'h00, fs});
		cmp_byte(bp_state, exp_state(step));
	endtask

	task automatic write_cell(input logic [7:0] a, input logic [7:0] d);
		cell_wr = '{wr_en: 1'b1, addr: a, data: d};
		@(posedge clk) #1;
		cell_wr.wr_en = 1'b0;
		if (a < 8'h04) mem[a[1:0]] = d;
		repeat (2) @(posedge clk) #1;
	endtask

	task automatic run_steps(input int n, input bit b2b);
		logic [7:0] wd;
		logic [1:0] wa;
		wd = 8'($urandom);
		wa = 2'($urandom);
		for (int i = 0; i < n; i++) begin
			refresh_step_tick = 1'b1;
			if (b2b && i == 0) cell_wr = '{wr_en: 1'b1, addr: {6'h00, wa}, data: wd};
			if (b2b && i == 1) cell_wr.wr_en = 1'b0;
			@(posedge clk) #1;
			if (!b2b || i == n - 1) refresh_step_tick = 1'b0;
			check_step(step == 0);
			// Write taken with step 0 tick shows from step 2 on
			if (b2b && i == 1) mem[wa] = wd;
			if (!b2b) begin
				repeat ($urandom_range(1, 3)) @(posedge clk) #1;
				check_step(1'b0);
			end
			step = (step + 1) % 8;
		end
		if (b2b) @(posedge clk) #1;
	endtask

	task automatic do_reset(input int n);
		rst_b = 1'b0;
		repeat (n) @(posedge clk) #1;
		rst_b = 1'b1;
		step = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		cmp_bp(backplane_line, '0);
		cmp_byte({seg_hi, seg_lo}, 8'h00);
		cmp_byte({7'h00, frame_start}, 8'h00);
		cmp_byte(bp_state, 8'h55);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(77));
		do_reset(6);
		run_steps(8, 1'b0);
		for (int f = 0; f < 6; f++) begin
			for (int c = 0; c < 4; c++) write_cell(8'(c), (f == 0) ? corners[c] : 8'($urandom));
			write_cell(8'($urandom_range(4, 255)), 8'($urandom));
			run_steps(8, f[0]);
		end
		run_steps(3, 1'b0);
		do_reset(2);
		run_steps(8, 1'b1);
		summarize();
	end

	initial begin
		#2000000;
		mismatches++;
		summarize();
	end
endmodule
